// >>> hdl/jdt_pkg.sv
// constants, field layouts and carrier types of the jtag debug transport bridge
// assumes a single processor clock domain; jtag pins arrive asynchronously
package jdt_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // instruction codes and data register lengths
   localparam int IR_LEN = 5;
   localparam logic [4:0] IR_IDENTIFICATION_CODE = 5'h01;
   localparam logic [4:0] IR_CSR = 5'h10;
   localparam logic [4:0] IR_DBUS = 5'h11;
   localparam logic [4:0] IR_CAPTURE_VAL = 5'h01;
   localparam logic [5:0] LEN_ID = 6'h20;
   localparam logic [5:0] LEN_CSR = 6'h20;
   localparam logic [5:0] LEN_DBUS = 6'h29;
   localparam logic [5:0] LEN_BYPASS = 6'h01;
   localparam int DR_MAX = 41;

   ////////////////////////////////////////////////////////////////////////////
   // identification register layout
   localparam logic [3:0] ID_VERSION = 4'h0;
   localparam logic [15:0] ID_PART = 16'h0000;
   localparam logic [10:0] ID_MAKER_DEFAULT = 11'h2a5; // arbitrary value, names no maker
   localparam logic ID_FIXED_ONE = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // transport control and status layout
   localparam int CSR_HARDRST_BIT = 17;
   localparam int CSR_ERRCLR_BIT = 16;
   localparam logic [2:0] CSR_IDLE = 3'h0;
   localparam logic [5:0] CSR_ABITS = 6'h06;
   localparam logic [3:0] CSR_VERSION = 4'h1;
   localparam logic [13:0] CSR_RSVD_HI = 14'h0000;
   localparam logic CSR_RSVD_15 = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // debug bus access layout and status codes
   localparam int DBUS_ADDR_LSB = 34;
   localparam int DBUS_DATA_LSB = 2;
   localparam logic [1:0] OP_NOP = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] ST_OK = 2'h0;
   localparam logic [1:0] ST_FAIL = 2'h2;
   localparam logic [1:0] ST_BUSY = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // timing: tck at most one fifth of sys_clk
   localparam int TCK_RATIO_MIN = 5;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [15:0] {
      TAP_RESET = 16'h0001,
      TAP_IDLE = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SH_DR = 16'h0010,
      TAP_EX1_DR = 16'h0020,
      TAP_PA_DR = 16'h0040,
      TAP_EX2_DR = 16'h0080,
      TAP_UPD_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SH_IR = 16'h0800,
      TAP_EX1_IR = 16'h1000,
      TAP_PA_IR = 16'h2000,
      TAP_EX2_IR = 16'h4000,
      TAP_UPD_IR = 16'h8000
   } jdt_tap_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] addr;
      logic [31:0] wdata;
   } jdt_dbus_req_t;

   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] rdata;
   } jdt_dbus_rsp_t;

endpackage : jdt_pkg

// >>> hdl/jdt_pin_sync.sv
// two-stage synchroniser for asynchronous jtag pins
// assumes the pins change no faster than the sys_clk can follow
`timescale 1ns/10ps
`default_nettype none
module jdt_pin_sync #(
   parameter int WIDTH = 3,
   parameter int STAGES = 2
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] sync_o
);
   import jdt_pkg::*;

   if (STAGES != SYNC_STAGES || WIDTH < 1) begin : g_check
      $error("jdt_pin_sync: unsupported width or stage count");
   end

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // the first stage feeds the second stage only
   always_comb begin
      meta_next = pin_i;
      sync_next = meta_reg;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg;

endmodule : jdt_pin_sync
`default_nettype wire

// >>> hdl/jdt_bridge.sv
// jtag tap and debug bus access bridge, oversampled in the sys_clk domain
// assumes tck at most a fifth of sys_clk and a controller that acks every request
//
// What this block does
// - no reset pin; tms sequence resets tap
// - debugger absent: tdi wired to tdo
// - one 5-bit instruction register selects data
// - code 00001 selects 32-bit identification
// - code 10000 selects 32-bit control/status
// - code 10001 selects 41-bit bus access
// - other codes select one-bit bypass
// - identification: zero version/part, maker code, one
// - status bit 17 resets bus, self-clears
// - status bit 16 clears sticky error
// - idle cycle field reads zero
// - bits 11:10 report bus operation status
// - bits 9:4 read address width six
// - bits 3:0 read version 0001
// - reserved status bits read zero
// - access bits 40:34 hold target address
// - access bits 33:2 carry data word
// - access bits 1:0: nop, read, write
// - halted cpu polls controller status register
`timescale 1ns/10ps
`default_nettype none
module jdt_bridge #(
   parameter bit DEBUG_EN = 1'b1,
   // arbitrary neutral maker code
   parameter logic [10:0] MAKER_CODE = jdt_pkg::ID_MAKER_DEFAULT
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic jtag_tck_i,
   input wire logic jtag_tms_i,
   input wire logic jtag_tdi_i,
   output logic jtag_tdo_o,
   output jdt_pkg::jdt_dbus_req_t dbus_req_o,
   input wire jdt_pkg::jdt_dbus_rsp_t dbus_rsp_i,
   output logic dbus_reset_o
);
   import jdt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin sampling; tck edges are only seen reliably at ratio 5 or more
   logic tck_s;
   logic tms_s;
   logic tdi_s;

   jdt_pin_sync #(.WIDTH(3), .STAGES(SYNC_STAGES)) u_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pin_i({jtag_tck_i, jtag_tms_i, jtag_tdi_i}),
      .sync_o({tck_s, tms_s, tdi_s})
   );

   function automatic jdt_tap_t tap_step(input jdt_tap_t s, input logic tms);
      unique case (s)
         TAP_RESET: tap_step = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_step = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_step = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: tap_step = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_step = tms ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR: tap_step = tms ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: tap_step = tms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_step = tms ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: tap_step = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: tap_step = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_step = tms ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR: tap_step = tms ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: tap_step = tms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_step = tms ? TAP_SEL_DR : TAP_IDLE;
         default: tap_step = TAP_RESET;
      endcase
   endfunction : tap_step

   function automatic logic [5:0] dr_len(input logic [4:0] ir);
      unique case (ir)
         IR_IDENTIFICATION_CODE: dr_len = LEN_ID;
         IR_CSR: dr_len = LEN_CSR;
         IR_DBUS: dr_len = LEN_DBUS;
         default: dr_len = LEN_BYPASS;
      endcase
   endfunction : dr_len

   ////////////////////////////////////////////////////////////////////////////
   // state
   jdt_tap_t state_reg, state_next;
   logic tck_prev_reg, tck_prev_next;
   logic [4:0] ir_reg, ir_next;
   logic [4:0] irsh_reg, irsh_next;
   logic [DR_MAX-1:0] sh_reg, sh_next;
   logic tdo_reg, tdo_next;
   logic busy_reg, busy_next;
   logic [1:0] sticky_reg, sticky_next;
   logic [31:0] rdata_reg, rdata_next;
   jdt_dbus_req_t req_reg, req_next;
   logic dbrst_reg, dbrst_next;

   logic tck_rise;
   logic tck_fall;
   logic upd_dr;
   logic [5:0] len;
   logic [1:0] op;
   logic [1:0] stat_now;

   assign tck_rise = tck_s & ~tck_prev_reg;
   assign tck_fall = ~tck_s & tck_prev_reg;
   assign len = dr_len(ir_reg);
   assign op = sh_reg[1:0];
   assign upd_dr = tck_rise && (tap_step(state_reg, tms_s) == TAP_UPD_DR);
   assign stat_now = busy_reg ? ST_BUSY : sticky_reg;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next = state_reg;
      tck_prev_next = tck_s;
      ir_next = ir_reg;
      irsh_next = irsh_reg;
      sh_next = sh_reg;
      tdo_next = tdo_reg;
      busy_next = busy_reg;
      sticky_next = sticky_reg;
      rdata_next = rdata_reg;
      req_next = req_reg;
      dbrst_next = 1'b0;

      if (tck_rise) begin
         state_next = tap_step(state_reg, tms_s);
         unique case (state_reg)
            TAP_RESET: ir_next = IR_IDENTIFICATION_CODE;
            TAP_CAP_IR: irsh_next = IR_CAPTURE_VAL;
            TAP_SH_IR: irsh_next = {tdi_s, irsh_reg[4:1]};
            TAP_CAP_DR: begin
               sh_next = '0;
               unique case (ir_reg)
                  IR_IDENTIFICATION_CODE: sh_next[31:0] = {ID_VERSION, ID_PART, MAKER_CODE,
                                              ID_FIXED_ONE};
                  IR_CSR: sh_next[31:0] = {CSR_RSVD_HI, 2'b00, CSR_RSVD_15, CSR_IDLE,
                                           stat_now, CSR_ABITS, CSR_VERSION};
                  IR_DBUS: begin
                     sh_next = {req_reg.addr, rdata_reg, stat_now};
                     if (busy_reg) begin
                        sticky_next = ST_BUSY;
                     end
                  end
                  default: sh_next[0] = 1'b0;
               endcase
            end
            TAP_SH_DR: begin
               sh_next = sh_reg >> 1;
               sh_next[len - 6'h01] = tdi_s;
            end
            default: begin
            end
         endcase
         if (state_reg == TAP_EX1_IR || state_reg == TAP_EX2_IR) begin
            if (tms_s) begin
               ir_next = irsh_reg;
            end
         end
      end

      if (tck_fall) begin
         tdo_next = (state_reg == TAP_SH_IR) ? irsh_reg[0] : sh_reg[0];
      end

      // completion before new commands so a command in the ack cycle still launches
      if (dbus_rsp_i.ack && busy_reg) begin
         busy_next = 1'b0;
         req_next.valid = 1'b0;
         if (!req_reg.write) begin
            rdata_next = dbus_rsp_i.rdata;
         end
      end

      if (upd_dr && ir_reg == IR_CSR) begin
         if (sh_reg[CSR_ERRCLR_BIT] || sh_reg[CSR_HARDRST_BIT]) begin
            sticky_next = ST_OK;
         end
         if (sh_reg[CSR_HARDRST_BIT]) begin
            busy_next = 1'b0;
            req_next.valid = 1'b0;
            dbrst_next = 1'b1;
         end
      end

      // error sets override the clears above
      if (dbus_rsp_i.ack && busy_reg && dbus_rsp_i.err && sticky_next == ST_OK) begin
         sticky_next = ST_FAIL;
      end

      if (upd_dr && ir_reg == IR_DBUS && op != OP_NOP) begin
         if (busy_reg && !dbus_rsp_i.ack) begin
            sticky_next = ST_BUSY;
         end else if (sticky_reg == ST_OK && (op == OP_READ || op == OP_WRITE)) begin
            // request goes to the controller whose status the halted cpu polls
            busy_next = 1'b1;
            req_next.valid = 1'b1;
            req_next.write = (op == OP_WRITE);
            req_next.addr = sh_reg[DBUS_ADDR_LSB +: 7];
            req_next.wdata = sh_reg[DBUS_DATA_LSB +: 32];
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg <= TAP_RESET;
         tck_prev_reg <= 1'b0;
         ir_reg <= IR_IDENTIFICATION_CODE;
         irsh_reg <= '0;
         sh_reg <= '0;
         tdo_reg <= 1'b0;
         busy_reg <= 1'b0;
         sticky_reg <= ST_OK;
         rdata_reg <= '0;
         req_reg <= '0;
         dbrst_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tck_prev_reg <= tck_prev_next;
         ir_reg <= ir_next;
         irsh_reg <= irsh_next;
         sh_reg <= sh_next;
         tdo_reg <= tdo_next;
         busy_reg <= busy_next;
         sticky_reg <= sticky_next;
         rdata_reg <= rdata_next;
         req_reg <= req_next;
         dbrst_reg <= dbrst_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; without the debugger the chain stays intact through a wire
   assign jtag_tdo_o = DEBUG_EN ? tdo_reg : jtag_tdi_i;
   assign dbus_req_o = DEBUG_EN ? req_reg : '0;
   assign dbus_reset_o = DEBUG_EN ? dbrst_reg : 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   AST_TMS_RESET: assert property (
      tck_rise && tms_s && state_reg == TAP_SEL_IR |=> state_reg == TAP_RESET
   ) else $error("tms high from select-ir did not reach reset");

   AST_IR_LOAD: assert property (
      tck_rise && tms_s && state_reg == TAP_EX1_IR |=> ir_reg == $past(irsh_reg)
   ) else $error("instruction not loaded on update");

   AST_ID_CAPTURE: assert property (
      tck_rise && state_reg == TAP_CAP_DR && ir_reg == IR_IDENTIFICATION_CODE
      |=> sh_reg[31:0] == {20'h00000, MAKER_CODE, 1'b1}
   ) else $error("identification capture wrong");

   AST_CSR_CAPTURE: assert property (
      tck_rise && state_reg == TAP_CAP_DR && ir_reg == IR_CSR
      |=> sh_reg[31:12] == 20'h00000 && sh_reg[9:0] == 10'h061
         && sh_reg[11:10] == $past(stat_now)
   ) else $error("control/status capture wrong");

   AST_BYPASS_CAPTURE: assert property (
      tck_rise && state_reg == TAP_CAP_DR && ir_reg != IR_IDENTIFICATION_CODE && ir_reg != IR_CSR
      && ir_reg != IR_DBUS |=> sh_reg[0] == 1'b0
   ) else $error("bypass capture not zero");

   // the tied-off variant never drives the bus, so the bus checks skip it
   AST_LAUNCH: assert property (
      DEBUG_EN && upd_dr && ir_reg == IR_DBUS && !busy_reg && sticky_reg == ST_OK
      && op == OP_WRITE |=> dbus_req_o.valid && dbus_req_o.write
         && dbus_req_o.addr == $past(sh_reg[40:34]) ##1 busy_reg
   ) else $error("write request not launched");

   AST_BUSY_STICKY: assert property (
      upd_dr && ir_reg == IR_DBUS && op != OP_NOP && busy_reg && !dbus_rsp_i.ack
      |=> sticky_reg == ST_BUSY && $stable(req_reg)
   ) else $error("overlapped request not flagged");

   AST_HARD_RESET: assert property (
      DEBUG_EN && upd_dr && ir_reg == IR_CSR && sh_reg[CSR_HARDRST_BIT]
      |=> dbus_reset_o && !busy_reg ##1 !dbus_reset_o
   ) else $error("hard reset not a single pulse");

   AST_ERR_CLEAR: assert property (
      upd_dr && ir_reg == IR_CSR && sh_reg[CSR_ERRCLR_BIT] && !dbus_rsp_i.ack
      |=> sticky_reg == ST_OK
   ) else $error("sticky error not cleared");

   AST_TDO_SHIFT: assert property (
      tck_fall && state_reg == TAP_SH_DR |=> tdo_reg == $past(sh_reg[0])
   ) else $error("tdo does not follow shift register");

   COV_WRITE: cover property (dbus_req_o.valid && dbus_req_o.write ##[1:20] dbus_rsp_i.ack);
   COV_READ_ERR: cover property (busy_reg && dbus_rsp_i.ack && dbus_rsp_i.err);
   COV_BUSY: cover property (sticky_reg == ST_BUSY);
   COV_HARD: cover property (dbus_reset_o);

endmodule : jdt_bridge
`default_nettype wire

// >>> tb/jdt_adapter_model.sv
// jtag adapter model: drives tck, tms and tdi and samples tdo
// assumes the bridge sys_clk; tck stands low between scans
`timescale 1ns/10ps
`default_nettype none
module jdt_adapter_model (
   input wire logic sys_clk_i,
   input wire logic tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one tck period is 8 sys_clk; tdo is taken late in the high phase
   task automatic bit_cyc(input logic tms, input logic tdi, output logic tdo);
      @(negedge sys_clk_i);
      tck_o = 1'b0;
      tms_o = tms;
      tdi_o = tdi;
      repeat (4) @(negedge sys_clk_i);
      tck_o = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      tdo = tdo_i;
   endtask : bit_cyc

   // idle: tck low, tdi no longer shows the last bit
   task automatic park();
      @(negedge sys_clk_i);
      tck_o = 1'b0;
      tdi_o = ~tdi_o;
   endtask : park

   task automatic reset_tap();
      logic x;
      repeat (6) bit_cyc(1'b1, 1'b0, x);
      bit_cyc(1'b0, 1'b0, x);
      park();
   endtask : reset_tap

   task automatic scan_ir(input logic [4:0] code, output logic [4:0] dout);
      logic x;
      bit_cyc(1'b1, 1'b0, x);
      bit_cyc(1'b1, 1'b0, x);
      bit_cyc(1'b0, 1'b0, x);
      bit_cyc(1'b0, 1'b0, x);
      for (int i = 0; i < 5; i++) begin
         bit_cyc(i == 4, code[i], dout[i]);
      end
      bit_cyc(1'b1, 1'b0, x);
      bit_cyc(1'b0, 1'b0, x);
      park();
   endtask : scan_ir

   // lsb first, len bits of din
   task automatic scan_dr(input int len, input logic [40:0] din, output logic [40:0] dout);
      logic x;
      dout = '0;
      bit_cyc(1'b1, 1'b0, x);
      bit_cyc(1'b0, 1'b0, x);
      bit_cyc(1'b0, 1'b0, x);
      for (int i = 0; i < len; i++) begin
         bit_cyc(i == len - 1, din[i], dout[i]);
      end
      bit_cyc(1'b1, 1'b0, x);
      bit_cyc(1'b0, 1'b0, x);
      park();
   endtask : scan_dr
endmodule : jdt_adapter_model
`default_nettype wire

// >>> tb/jdt_bridge_tb_top.sv
// testbench of the jtag debug transport bridge
// assumes the adapter model and a simple acking debug controller stub
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module jdt_bridge_tb_top;
   import jdt_pkg::*;
   localparam logic [10:0] MAKER = 11'h155; // arbitrary neutral maker code
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic tck, tms, tdi, tdo, tdo_off, dbus_rst;
   jdt_dbus_req_t req;
   jdt_dbus_rsp_t rsp = '0;
   int n_fail = 0, checks_done = 0, cyc = 0, wait_cnt = 0, n_hrst = 0;
   logic [6:0] lst_addr;
   logic [31:0] lst_wdata;
   logic lst_write;
   logic [40:0] d;
   logic [4:0] ir;
   logic [4:0] byp [4] = '{5'h00, 5'h02, 5'h12, 5'h1f};

   always #25 sys_clk = ~sys_clk;

   jdt_adapter_model i_jdt_adapter_model (.sys_clk_i(sys_clk), .tdo_i(tdo), .tck_o(tck),
      .tms_o(tms), .tdi_o(tdi));
   jdt_bridge #(.MAKER_CODE(MAKER)) i_jdt_bridge (.sys_clk_i(sys_clk), .rst_i(rst),
      .jtag_tck_i(tck), .jtag_tms_i(tms), .jtag_tdi_i(tdi), .jtag_tdo_o(tdo),
      .dbus_req_o(req), .dbus_rsp_i(rsp), .dbus_reset_o(dbus_rst));
   jdt_bridge #(.DEBUG_EN(1'b0)) i_jdt_bridge_off (.sys_clk_i(sys_clk), .rst_i(rst),
      .jtag_tck_i(tck), .jtag_tms_i(tms), .jtag_tdi_i(tdi), .jtag_tdo_o(tdo_off),
      .dbus_req_o(), .dbus_rsp_i('0), .dbus_reset_o());

   function automatic logic [31:0] exp_rd(input logic [6:0] a);
      return {25'h0, a} ^ 32'hc3a5_0f0f;
   endfunction : exp_rd

   ////////////////////////////////////////////////////////////////////////////
   // controller stub: 7f answers with error, 7e answers very late
   always @(negedge sys_clk) begin
      cyc <= cyc + 1;
      rsp.ack <= 1'b0;
      rsp.rdata <= ~rsp.rdata;
      if (dbus_rst) n_hrst <= n_hrst + 1;
      if (rst || !req.valid || rsp.ack) wait_cnt <= 0;
      else begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt == ((req.addr == 7'h7e) ? 2000 : 2)) begin
            rsp.ack <= 1'b1;
            rsp.err <= (req.addr == 7'h7f);
            rsp.rdata <= exp_rd(req.addr);
            {lst_write, lst_addr, lst_wdata} <= {req.write, req.addr, req.wdata};
         end
      end
   end

   task automatic end_of_test();
      if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   always @(posedge sys_clk) begin
      if (cyc == 30000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic dr(input logic [4:0] code, input int len, input logic [40:0] din);
      i_jdt_adapter_model.scan_ir(code, ir);
      `CHK(ir, IR_CAPTURE_VAL)
      i_jdt_adapter_model.scan_dr(len, din, d);
   endtask : dr

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      repeat (3) @(negedge sys_clk);
      i_jdt_adapter_model.reset_tap();
      dr(IR_IDENTIFICATION_CODE, 32, 41'h0);
      `CHK(d[31:0], ({4'h0, 16'h0, MAKER, 1'b1}))
      dr(IR_CSR, 32, 41'h0);
      `CHK(d[31:0], 32'h0000_0061)
      foreach (byp[i]) begin
         dr(byp[i], 2, 41'h3);
         `CHK(d[1:0], 2'b10)
         `CHK(tdo_off, tdi)
      end
      i_jdt_adapter_model.scan_ir(IR_CSR, ir);
      i_jdt_adapter_model.reset_tap();
      i_jdt_adapter_model.scan_dr(32, 41'h0, d);
      `CHK(d[31:0], ({4'h0, 16'h0, MAKER, 1'b1}))
      dr(IR_DBUS, 41, {7'h05, 32'h1234_5678, OP_WRITE});
      `CHK(({lst_write, lst_addr, lst_wdata}), ({1'b1, 7'h05, 32'h1234_5678}))
      dr(IR_DBUS, 41, {7'h05, 32'h0, OP_READ});
      `CHK(({lst_write, lst_addr}), 8'h05)
      dr(IR_DBUS, 41, {7'h05, 32'h0, OP_NOP});
      `CHK(d, ({7'h05, exp_rd(7'h05), ST_OK}))
      // failed read, then a read that must be ignored while the error sticks
      dr(IR_DBUS, 41, {7'h7f, 32'h0, OP_READ});
      dr(IR_DBUS, 41, {7'h05, 32'h0, OP_READ});
      `CHK(d[1:0], ST_FAIL)
      `CHK(lst_addr, 7'h7f)
      dr(IR_CSR, 32, 41'h1_0000);
      `CHK(d[11:10], ST_FAIL)
      dr(IR_CSR, 32, 41'h0);
      `CHK(d[31:0], 32'h0000_0061)
      // a read overlapping a slow pending one is refused, then the slow one is aborted
      dr(IR_DBUS, 41, {7'h7e, 32'h0, OP_READ});
      dr(IR_DBUS, 41, {7'h05, 32'h0, OP_READ});
      `CHK(d[1:0], ST_BUSY)
      `CHK(req.addr, 7'h7e)
      `CHK(n_hrst, 0)
      dr(IR_CSR, 32, 41'h2_0000);
      `CHK(d[11:10], ST_BUSY)
      `CHK(n_hrst, 1)
      `CHK(req.valid, 1'b0)
      dr(IR_CSR, 32, 41'h0);
      `CHK(d[31:0], 32'h0000_0061)
      // operation code 11 is neither read nor write and launches nothing
      dr(IR_DBUS, 41, {7'h33, 32'h0, 2'b11});
      `CHK(lst_addr, 7'h7f)
      repeat (20) @(negedge sys_clk);
      end_of_test();
   end
endmodule : jdt_bridge_tb_top
`default_nettype wire
